// ### rtl/blinds_channel.sv
/*
 blinds_channel: one push-button input run as a blinds channel, with APB
 registers, debounce, long/short push, double-click, block and restoration.
 Assumes a pressed contact reads 1 on key_in, synchronous to pclk;
 restore_pulse marks bus and mains restoration for one cycle.
*/
// The APB register port and the address map were decided locally.
`timescale 1ns/1ps
module blinds_channel
	import blinds_pkg::*;
#(
	parameter int TICK_CYC = TICK_CYCLES,
	parameter int PW = 18
)
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic key_in,
	input wire logic restore_pulse,
	output logic cmd_valid,
	output logic [1:0] cmd_kind,
	output logic cmd_down,
	output logic dclick_pulse
);
	typedef enum logic [2:0] {ST_IDLE, ST_PRESS, ST_HELD, ST_LATCH, ST_DCWAIT, ST_DCHELD} btn_t;

	typedef struct packed {
		logic [PW-1:0] pre;
		logic tick;
		logic [31:0] ctrl;
		logic blk_val;
		logic blocked;
		logic lvl_q;
		btn_t st;
		logic [TW-1:0] el;
		logic stop_pend;
		logic go_down;
		logic rpend;
		logic rdown;
		logic rdc;
		logic [TW-1:0] rcnt;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
		logic cmd_valid;
		logic [1:0] cmd_kind;
		logic cmd_down;
		logic dclick;
	} chan_st_t;

	localparam chan_st_t S_RST = '{ctrl: CTRL_RESET, st: ST_IDLE, default: '0};

	chan_st_t s;
	chan_st_t n;
	deb_if db();
	logic [TW-1:0] long_ms;
	logic [TW-1:0] dc_ms;
	logic blk_now;
	logic press;
	logic rel;
	logic dir_dn;

	key_debounce u_deb (
		.pclk(pclk),
		.presetn(presetn),
		.ce(ce),
		.key_in(key_in),
		.db(db)
	);

	////////////////////////////////////////////////////////////////////////////
	// outputs straight from the state register
	assign prdata = s.prdata;
	assign pready = s.pready;
	assign pslverr = s.pslverr;
	assign cmd_valid = s.cmd_valid;
	assign cmd_kind = s.cmd_kind;
	assign cmd_down = s.cmd_down;
	assign dclick_pulse = s.dclick;
	assign db.tick = s.tick;
	assign db.sel = s.ctrl[F_DEB+:3];

	// thresholds in ms, edges of the clean level, block state
	assign long_ms = TW'(LONG_BASE_MS + TW'(s.ctrl[F_LONG+:3]) * LONG_STEP_MS);
	assign dc_ms = TW'(LONG_BASE_MS + TW'(s.ctrl[F_DCWIN+:3]) * LONG_STEP_MS);
	assign press = db.level & ~s.lvl_q;
	assign rel = ~db.level & s.lvl_q;
	// ignore setting makes the block object inert
	assign blk_now = (s.blk_val ^ s.ctrl[F_POL]) & (s.ctrl[F_BSET+:2] != BSET_IGNORE);

	// direction by mode; one-button follows the alternating flag
	always_comb
	begin
		case (s.ctrl[F_MODE+:2])
			MODE_DOWN: dir_dn = 1'b1;
			MODE_UP: dir_dn = 1'b0;
			default: dir_dn = s.go_down;
		endcase
	end

	////////////////////////////////////////////////////////////////////////////
	// next state: prescaler, button machine, restoration, block, APB
	always_comb
	begin
		logic e_v;
		logic [1:0] e_k;
		logic e_dc;
		logic [3:0] r;
		logic r_go;
		logic r_dn;
		logic [1:0] r_di;
		logic [31:0] status;
		e_v = 1'b0;
		e_k = CMD_STEP;
		e_dc = 1'b0;
		r = s.ctrl[F_REST+:4];
		r_go = 1'b1;
		r_dn = 1'b0;
		r_di = 2'h0;
		status = '0;
		n = s;
		n.lvl_q = db.level;

		// ms tick; the count is fine since a ms is far above the cycle
		if (s.pre == PW'(TICK_CYC - 1))
		begin
			n.pre = '0;
			n.tick = 1'b1;
		end
		else
		begin
			n.pre = s.pre + PW'(1);
			n.tick = 1'b0;
		end

		// elapsed ms since the press began, saturating
		if (s.tick && s.el != '1)
			n.el = s.el + TW'(1);

		case (s.st)
			ST_IDLE:
			begin
				if (press)
				begin
					n.el = '0;
					n.stop_pend = 1'b0;
					n.st = ST_PRESS;
				end
			end
			ST_PRESS:
			begin
				if (rel)
				begin
					if (s.stop_pend)
					begin
						e_v = 1'b1;
						e_k = CMD_STOP;
						n.st = ST_IDLE;
					end
					else if (s.ctrl[F_DCEN])
						n.st = ST_DCWAIT;
					else
					begin
						e_v = 1'b1;
						e_k = CMD_STEP;
						n.st = ST_IDLE;
					end
				end
				else if (s.el >= long_ms)
				begin
					e_v = 1'b1;
					e_k = CMD_MOVE;
					if (s.ctrl[F_MODE+:2] == MODE_ONE)
						n.go_down = ~s.go_down;
					n.st = ST_HELD;
				end
			end
			ST_HELD:
			begin
				if (rel)
				begin
					if (!s.ctrl[F_STOPM])
					begin
						e_v = 1'b1;
						e_k = CMD_STOP;
						n.st = ST_IDLE;
					end
					else
						n.st = ST_LATCH;
				end
			end
			ST_LATCH:
			begin
				// movement keeps running; a short push will stop it
				if (press)
				begin
					n.el = '0;
					n.stop_pend = 1'b1;
					n.st = ST_PRESS;
				end
			end
			ST_DCWAIT:
			begin
				// window counts from the first click's start
				if (s.el >= dc_ms)
				begin
					e_v = 1'b1;
					e_k = CMD_STEP;
					n.el = '0;
					n.st = press ? ST_PRESS : ST_IDLE;
				end
				else if (press)
				begin
					e_dc = 1'b1;
					n.st = ST_DCHELD;
				end
			end
			ST_DCHELD:
			begin
				if (rel)
					n.st = ST_IDLE;
			end
			default: n.st = ST_IDLE;
		endcase

		// button commands die while blocked; the machine still tracks the key
		n.cmd_valid = e_v & ~blk_now;
		n.cmd_kind = e_k;
		n.cmd_down = dir_dn;
		n.dclick = e_dc & ~blk_now;

		// restoration countdown; immediate means a zero count
		if (s.rpend && s.rcnt == '0)
		begin
			n.rpend = 1'b0;
			if (s.rdc)
				n.dclick = 1'b1;
			else
			begin
				n.cmd_valid = 1'b1;
				n.cmd_kind = CMD_MOVE;
				n.cmd_down = s.rdown;
			end
		end
		else if (s.rpend && s.tick)
			n.rcnt = s.rcnt - TW'(1);

		// restoration start: decode response and delay
		if (r == REST_UP)
			r_dn = 1'b0;
		else if (r == REST_DOWN)
			r_dn = 1'b1;
		else if (r >= REST_UP5 && r < REST_DN5)
			r_di = 2'(r - REST_DOWN);
		else if (r >= REST_DN5 && r <= REST_DN15)
		begin
			r_dn = 1'b1;
			r_di = 2'(r - REST_DN5 + 4'h1);
		end
		else
			r_go = 1'b0;
		if (restore_pulse)
		begin
			n.go_down = 1'b0;
			if (s.ctrl[F_RDC])
			begin
				n.rpend = 1'b1;
				n.rdc = 1'b1;
				n.rcnt = REST_DLY_MS[s.ctrl[F_RDCDLY+:2]];
			end
			else if (r_go)
			begin
				n.rpend = 1'b1;
				n.rdc = 1'b0;
				n.rdown = r_dn;
				n.rcnt = REST_DLY_MS[r_di];
			end
			else
				n.rpend = 1'b0;
		end

		// block edge moves win over button and restoration commands in that cycle
		n.blocked = blk_now;
		if (blk_now && !s.blocked && s.ctrl[F_BSET+:2] >= BSET_UP)
		begin
			n.cmd_valid = 1'b1;
			n.cmd_kind = CMD_MOVE;
			n.cmd_down = (s.ctrl[F_BSET+:2] == BSET_DOWN);
		end
		if (!blk_now && s.blocked && (s.ctrl[F_BCAN+:2] == BCAN_UP || s.ctrl[F_BCAN+:2] == BCAN_DOWN))
		begin
			n.cmd_valid = 1'b1;
			n.cmd_kind = CMD_MOVE;
			n.cmd_down = (s.ctrl[F_BCAN+:2] == BCAN_DOWN);
		end

		// APB: one wait state, write lands on the edge that samples pready
		status[S_LEVEL] = db.level;
		status[S_BLOCKED] = s.blocked;
		status[S_GODOWN] = s.go_down;
		status[S_RPEND] = s.rpend;
		status[S_MOVING] = (s.st == ST_HELD) || (s.st == ST_LATCH);
		n.pready = 1'b0;
		n.pslverr = 1'b0;
		if (psel && penable && !s.pready)
		begin
			n.pready = 1'b1;
			case (paddr)
				ADDR_CTRL: n.prdata = s.ctrl;
				ADDR_BLOCK: n.prdata = {31'h0000_0000, s.blk_val};
				ADDR_STATUS: n.prdata = status;
				default:
				begin
					n.prdata = '0;
					n.pslverr = 1'b1;
				end
			endcase
		end
		if (psel && penable && s.pready && pwrite)
		begin
			if (paddr == ADDR_CTRL)
				n.ctrl = pwdata & CTRL_MASK;
			else if (paddr == ADDR_BLOCK)
				n.blk_val = pwdata[0];
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			s <= S_RST;
		else if (ce)
			s <= n;
	end

	////////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn || !ce);

	property p_long;
		(s.cmd_valid && s.cmd_kind == CMD_MOVE && $past(s.st) == ST_PRESS && s.st == ST_HELD)
			|-> $past(s.el) >= $past(long_ms);
	endproperty
	a_long: assert property (p_long) else $error("move before long threshold");

	property p_short;
		($past(s.st) == ST_PRESS && s.st == ST_DCWAIT) |-> $past(s.el) < $past(long_ms);
	endproperty
	a_short: assert property (p_short) else $error("long press taken as short");

	property p_dcwin;
		($past(s.st) == ST_DCWAIT && s.st == ST_DCHELD) |-> $past(s.el) < $past(dc_ms) && $past(s.ctrl[F_DCEN]);
	endproperty
	a_dcwin: assert property (p_dcwin) else $error("double-click outside window");

	property p_nodc;
		($past(s.st) == ST_PRESS && !$past(s.ctrl[F_DCEN])) |-> s.st != ST_DCWAIT;
	endproperty
	a_nodc: assert property (p_nodc) else $error("double-click wait while disabled");

	property p_pol;
		($past(s.blk_val) != $past(s.ctrl[F_POL]) && $past(s.ctrl[F_BSET+:2]) != BSET_IGNORE) |-> s.blocked;
	endproperty
	a_pol: assert property (p_pol) else $error("block polarity not honoured");

	property p_dir;
		(s.cmd_valid && s.cmd_kind == CMD_MOVE && s.st == ST_HELD && $past(s.st) == ST_PRESS
			&& $stable(s.blocked) && !$past(s.rpend) && $stable(s.ctrl))
			|-> (s.ctrl[F_MODE+:2] == MODE_DOWN) ? s.cmd_down
			: (s.ctrl[F_MODE+:2] == MODE_UP) ? !s.cmd_down : (s.go_down != $past(s.go_down));
	endproperty
	a_dir: assert property (p_dir) else $error("move direction wrong for mode");

	property p_stop;
		($past(s.st) == ST_HELD && s.st == ST_IDLE && !$past(blk_now) && $stable(s.blocked) && !$past(s.rpend))
			|-> s.cmd_valid && s.cmd_kind == CMD_STOP;
	endproperty
	a_stop: assert property (p_stop) else $error("no stop on release");

	property p_blk;
		($past(blk_now) && $stable(s.blocked) && !$past(s.rpend)) |-> !s.cmd_valid && !s.dclick;
	endproperty
	a_blk: assert property (p_blk) else $error("command sent while blocked");

	property p_rest;
		(restore_pulse && s.ctrl[F_REST+:4] == REST_UP && !s.ctrl[F_RDC] && !blk_now && s.blocked == blk_now)
			|-> ##2 s.cmd_valid && s.cmd_kind == CMD_MOVE && !s.cmd_down;
	endproperty
	a_rest: assert property (p_rest) else $error("restoration raise missing");

	property p_rdc;
		(restore_pulse && s.ctrl[F_RDC] && s.ctrl[F_RDCDLY+:2] == 2'h0) |-> ##2 s.dclick;
	endproperty
	a_rdc: assert property (p_rdc) else $error("restoration double-click missing");

	property p_bset;
		($rose(s.blocked) && $past(s.ctrl[F_BSET+:2]) == BSET_UP) |-> s.cmd_valid && !s.cmd_down;
	endproperty
	a_bset: assert property (p_bset) else $error("block set raise missing");

	property p_bcan;
		($fell(s.blocked) && $past(s.ctrl[F_BCAN+:2]) == BCAN_DOWN) |-> s.cmd_valid && s.cmd_down;
	endproperty
	a_bcan: assert property (p_bcan) else $error("block cancel lower missing");
endmodule

// ### rtl/blinds_pkg.sv
/*
 blinds_pkg: register map, field positions, reset values, timing counts and
 enumerations for the blinds push-button channel.
 Assumes a 250 MHz pclk and a 32-bit APB master; times are kept in ms.
*/
// Overview of operation
// - a new input level counts only after holding for the selected debounce time
// - press held at least the long threshold is long, otherwise short
// - second click starting inside the window makes a double-click
// - with double-click disabled no double-click recognition happens
// - block value polarity selectable: block with 1 or block with 0
// - one-button mode: short push steps, long push moves
// - down mode: short push steps, long push lowers
// - up mode: short push steps, long push raises
// - movement stops on release or on a later short push, as selected
// - on restoration do nothing, raise or lower, now or after 5/10/15 s
// - on block set: ignore block, nothing, raise or lower
// - on block cancel: nothing, raise or lower
// - restoration may send the double-click event, now or after 5/10/15 s
package blinds_pkg;
	localparam int TW = 14;

	// register byte addresses
	localparam logic [11:0] ADDR_CTRL = 12'h000;
	localparam logic [11:0] ADDR_BLOCK = 12'h004;
	localparam logic [11:0] ADDR_STATUS = 12'h008;

	// control field positions
	localparam int F_DEB = 0;
	localparam int F_LONG = 3;
	localparam int F_DCEN = 6;
	localparam int F_DCWIN = 7;
	localparam int F_POL = 10;
	localparam int F_MODE = 11;
	localparam int F_STOPM = 13;
	localparam int F_REST = 14;
	localparam int F_BSET = 18;
	localparam int F_BCAN = 20;
	localparam int F_RDC = 22;
	localparam int F_RDCDLY = 23;
	localparam logic [31:0] CTRL_MASK = 32'h01FF_FFFF;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0001;

	// status field positions
	localparam int S_LEVEL = 0;
	localparam int S_BLOCKED = 1;
	localparam int S_GODOWN = 2;
	localparam int S_RPEND = 3;
	localparam int S_MOVING = 4;

	// timing: one tick per millisecond
	localparam int CLK_PERIOD_PS = 32'h0000_0FA0;
	localparam int PS_PER_MS = 32'h3B9A_CA00;
	localparam int TICK_MS = 32'h0000_0001;
	localparam int TICK_CYCLES = TICK_MS * (PS_PER_MS / CLK_PERIOD_PS);
	// debounce 10000,5000,1000,200,100,80,50,30 ms (index 7 down to 0)
	localparam logic [7:0][TW-1:0] DEB_MS = {14'h2710, 14'h1388, 14'h03E8, 14'h00C8,
		14'h0064, 14'h0050, 14'h0032, 14'h001E};
	localparam logic [TW-1:0] LONG_BASE_MS = 14'h012C;
	localparam logic [TW-1:0] LONG_STEP_MS = 14'h0064;
	// restoration delays 15000,10000,5000,0 ms
	localparam logic [3:0][TW-1:0] REST_DLY_MS = {14'h3A98, 14'h2710, 14'h1388, 14'h0000};

	// restoration codes
	localparam logic [3:0] REST_UP = 4'h1;
	localparam logic [3:0] REST_DOWN = 4'h2;
	localparam logic [3:0] REST_UP5 = 4'h3;
	localparam logic [3:0] REST_DN5 = 4'h6;
	localparam logic [3:0] REST_DN15 = 4'h8;
	// block set / cancel codes
	localparam logic [1:0] BSET_IGNORE = 2'h0;
	localparam logic [1:0] BSET_UP = 2'h2;
	localparam logic [1:0] BSET_DOWN = 2'h3;
	localparam logic [1:0] BCAN_UP = 2'h1;
	localparam logic [1:0] BCAN_DOWN = 2'h2;

	typedef enum logic [1:0] {MODE_ONE, MODE_DOWN, MODE_UP} mode_t;
	typedef enum logic [1:0] {CMD_STEP, CMD_MOVE, CMD_STOP} cmd_kind_t;
endpackage

// ### rtl/deb_if.sv
/*
 deb_if: ms tick and debounce selection into the debouncer, clean level back.
 Assumes both ends run on pclk.
*/
`timescale 1ns/1ps
interface deb_if;
	logic tick;
	logic [2:0] sel;
	logic level;
	modport src (input tick, input sel, output level);
	modport sink (output tick, output sel, input level);
endinterface

// ### rtl/key_debounce.sv
/*
 key_debounce: accepts a changed contact level once it has held for the
 selected number of ms ticks.
 Assumes key_in synchronous to pclk; tick is one pclk wide, once per ms.
*/
`timescale 1ns/1ps
module key_debounce
	import blinds_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	input wire logic key_in,
	deb_if.src db
);
	typedef struct packed {
		logic level;
		logic [TW-1:0] cnt;
	} deb_st_t;

	deb_st_t s;
	deb_st_t n;

	assign db.level = s.level;

	////////////////////////////////////////////////////////////////////////////
	// any bounce back to the held level restarts the wait
	always_comb
	begin
		n = s;
		if (key_in == s.level)
			n.cnt = '0;
		else if (db.tick)
		begin
			if (s.cnt + TW'(1) >= DEB_MS[db.sel])
			begin
				n.level = key_in;
				n.cnt = '0;
			end
			else
				n.cnt = s.cnt + TW'(1);
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			s <= '0;
		else if (ce)
			s <= n;
	end

	////////////////////////////////////////////////////////////////////////////
	property p_deb;
		@(posedge pclk) disable iff (!presetn || !ce)
		(s.level != $past(s.level)) |-> (s.level == $past(key_in)) && $past(db.tick);
	endproperty
	a_deb: assert property (p_deb) else $error("level changed without a settled input");
endmodule

// ### tb/blinds_partner.sv
/*
 blinds_partner: push-button contact and blinds actuator seen from the bus side.
 Assumes key_in is sampled on pclk and that TK cycles make one ms tick.
*/
`timescale 1ns/1ps
module blinds_partner
#(
	parameter int TK = 4
)
(
	input wire logic pclk,
	input wire logic cmd_valid,
	input wire logic [1:0] cmd_kind,
	input wire logic cmd_down,
	input wire logic dclick_pulse,
	output logic key_in
);
	logic [2:0] seen[$];
	int dclicks;

	initial
	begin
		key_in = 1'b0;
		dclicks = 0;
	end

	////////////////////////////////////////////////////////////////////////
	// actuator side: log every command, pulses last one cycle so one sample each
	always @(posedge pclk)
	begin
		if (cmd_valid === 1'b1)
			seen.push_back({cmd_kind, cmd_down});
		if (dclick_pulse === 1'b1)
			dclicks++;
	end

	////////////////////////////////////////////////////////////////////////
	// contact side: a clean press held for hold_ms, then released for gap_ms
	task automatic push(input int hold_ms, input int gap_ms);
		@(posedge pclk);
		key_in <= 1'b1;
		repeat (hold_ms * TK) @(posedge pclk);
		key_in <= 1'b0;
		repeat (gap_ms * TK) @(posedge pclk);
	endtask
endmodule

// ### tb/testbench.sv
/*
 testbench: drives the blinds channel over APB and through the button model,
 checks issued commands and registers. Assumes ms ticks shortened to 4 cycles.
*/
`timescale 1ns/1ps
module testbench
	import blinds_pkg::*;
;
	localparam int TK = 4;
	logic pclk, presetn, ce, psel, penable, pwrite, restore_pulse, key_in;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic pready, pslverr, cmd_valid, cmd_down, dclick_pulse, err;
	logic [1:0] cmd_kind;
	int fail_count, samples_checked, d0;

	blinds_channel #(.TICK_CYC(TK)) blinds_channel_i (.pclk(pclk), .presetn(presetn), .ce(ce),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .key_in(key_in),
		.restore_pulse(restore_pulse), .cmd_valid(cmd_valid), .cmd_kind(cmd_kind),
		.cmd_down(cmd_down), .dclick_pulse(dclick_pulse));
	blinds_partner #(.TK(TK)) blinds_partner_i (.pclk(pclk), .cmd_valid(cmd_valid),
		.cmd_kind(cmd_kind), .cmd_down(cmd_down), .dclick_pulse(dclick_pulse), .key_in(key_in));

	// 250 MHz clock
	initial
	begin
		pclk = 1'b0;
		forever #2 pclk = ~pclk;
	end

	////////////////////////////////////////////////////////////////////////
	// reporting
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic wrap_up();
		$display("mismatches %0d, comparisons %0d", fail_count, samples_checked);
		if (fail_count == 0 && samples_checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////
	// stimulus helpers
	task automatic do_reset();
		presetn <= 1'b0;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		blinds_partner_i.seen.delete();
	endtask

	// one APB transfer; the request holds until pready is sampled high
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'b1 && n < 50);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 50)
		begin
			fail_count++;
			wrap_up();
		end
	endtask

	task automatic ms(input int n);
		repeat (n * TK) @(posedge pclk);
	endtask

	// pop the oldest command; a missing one pops as unknown and fails
	task automatic expect_cmd(input logic [1:0] k, input logic d, input bit chk_d);
		logic [2:0] v;
		v = 3'bxxx;
		if (blinds_partner_i.seen.size() > 0)
			v = blinds_partner_i.seen.pop_front();
		check({30'h0, v[2:1]}, {30'h0, k});
		if (chk_d)
			check({31'h0, v[0]}, {31'h0, d});
	endtask

	task automatic pulse_restore();
		@(posedge pclk);
		restore_pulse <= 1'b1;
		@(posedge pclk);
		restore_pulse <= 1'b0;
	endtask

	////////////////////////////////////////////////////////////////////////
	// main sequence
	initial
	begin
		fail_count = 0;
		samples_checked = 0;
		presetn = 1'b0;
		ce = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0000_0000;
		restore_pulse = 1'b0;
		do_reset();
		// register map, read-only status, unmapped place
		apb(1'b0, ADDR_CTRL, 32'h0);
		check(rd, 32'h0000_0001);
		apb(1'b1, ADDR_STATUS, 32'h0000_00FF);
		apb(1'b0, ADDR_STATUS, 32'h0);
		check(rd, 32'h0000_0000);
		apb(1'b0, 12'h00C, 32'h0);
		check({31'h0, err}, 32'h0000_0001);
		check(rd, 32'h0000_0000);
		apb(1'b1, ADDR_CTRL, 32'hFFFF_FFFF);
		apb(1'b0, ADDR_CTRL, 32'h0);
		check(rd, CTRL_MASK);
		do_reset();
		// a 20 ms bounce under 50 ms debounce is never accepted
		blinds_partner_i.push(20, 100);
		check(blinds_partner_i.seen.size(), 0);
		// up then down mode: short steps, long moves, release stops
		for (int m = 0; m < 2; m++)
		begin
			apb(1'b1, ADDR_CTRL, m ? 32'h0000_0801 : 32'h0000_1001);
			blinds_partner_i.push(100, 100);
			expect_cmd(2'h0, 1'b0, 1'b0);
			blinds_partner_i.push(500, 100);
			expect_cmd(2'h1, m[0], 1'b1);
			expect_cmd(2'h2, 1'b0, 1'b0);
		end
		// longest threshold: a 500 ms hold stays short, a longer hold moves
		apb(1'b1, ADDR_CTRL, 32'h0000_1039);
		blinds_partner_i.push(500, 100);
		expect_cmd(2'h0, 1'b0, 1'b0);
		blinds_partner_i.push(1200, 100);
		expect_cmd(2'h1, 1'b0, 1'b1);
		expect_cmd(2'h2, 1'b0, 1'b0);
		// one-button: long pushes alternate, raising first
		do_reset();
		for (int i = 0; i < 2; i++)
		begin
			blinds_partner_i.push(500, 100);
			expect_cmd(2'h1, i[0], 1'b1);
			expect_cmd(2'h2, 1'b0, 1'b0);
		end
		blinds_partner_i.push(100, 100);
		expect_cmd(2'h0, 1'b0, 1'b0);
		// stop by a later short operation, not by release
		apb(1'b1, ADDR_CTRL, 32'h0000_3001);
		blinds_partner_i.push(500, 100);
		expect_cmd(2'h1, 1'b0, 1'b1);
		check(blinds_partner_i.seen.size(), 0);
		blinds_partner_i.push(100, 100);
		expect_cmd(2'h2, 1'b0, 1'b0);
		// block: set raises, presses dropped, cancel lowers, polarity flips
		do_reset();
		apb(1'b1, ADDR_CTRL, 32'h0028_1001);
		apb(1'b1, ADDR_BLOCK, 32'h0000_0001);
		ms(2);
		expect_cmd(2'h1, 1'b0, 1'b1);
		apb(1'b0, ADDR_STATUS, 32'h0);
		check({31'h0, rd[S_BLOCKED]}, 32'h0000_0001);
		blinds_partner_i.push(100, 100);
		check(blinds_partner_i.seen.size(), 0);
		apb(1'b1, ADDR_BLOCK, 32'h0000_0000);
		ms(2);
		expect_cmd(2'h1, 1'b1, 1'b1);
		apb(1'b1, ADDR_CTRL, 32'h0028_1401);
		ms(2);
		expect_cmd(2'h1, 1'b0, 1'b1);
		apb(1'b0, ADDR_STATUS, 32'h0);
		check({31'h0, rd[S_BLOCKED]}, 32'h0000_0001);
		// restoration: immediate raise and lower, then lower after 5 s
		do_reset();
		for (int m = 0; m < 2; m++)
		begin
			apb(1'b1, ADDR_CTRL, m ? 32'h0000_9001 : 32'h0000_5001);
			pulse_restore();
			ms(2);
			expect_cmd(2'h1, m[0], 1'b1);
		end
		apb(1'b1, ADDR_CTRL, 32'h0001_9001);
		pulse_restore();
		apb(1'b0, ADDR_STATUS, 32'h0);
		check({31'h0, rd[S_RPEND]}, 32'h0000_0001);
		ms(4900);
		check(blinds_partner_i.seen.size(), 0);
		ms(200);
		expect_cmd(2'h1, 1'b1, 1'b1);
		d0 = blinds_partner_i.dclicks;
		apb(1'b1, ADDR_CTRL, 32'h0040_1001);
		pulse_restore();
		ms(2);
		check(blinds_partner_i.dclicks - d0, 1);
		// clock enable low freezes the channel: a long push is never seen
		@(posedge pclk);
		ce <= 1'b0;
		blinds_partner_i.push(500, 100);
		check(blinds_partner_i.seen.size(), 0);
		ce <= 1'b1;
		blinds_partner_i.push(100, 100);
		expect_cmd(2'h0, 1'b0, 1'b0);
		// double-click inside a 300 ms window, then with detection off
		do_reset();
		apb(1'b1, ADDR_CTRL, 32'h0000_1041);
		d0 = blinds_partner_i.dclicks;
		blinds_partner_i.push(100, 100);
		blinds_partner_i.push(100, 400);
		check(blinds_partner_i.dclicks - d0, 1);
		blinds_partner_i.seen.delete();
		// second click after the window: two single steps, no double-click
		blinds_partner_i.push(100, 400);
		blinds_partner_i.push(100, 400);
		check(blinds_partner_i.dclicks - d0, 1);
		expect_cmd(2'h0, 1'b0, 1'b0);
		expect_cmd(2'h0, 1'b0, 1'b0);
		apb(1'b1, ADDR_CTRL, 32'h0000_1001);
		blinds_partner_i.push(100, 100);
		blinds_partner_i.push(100, 400);
		check(blinds_partner_i.dclicks - d0, 1);
		expect_cmd(2'h0, 1'b0, 1'b0);
		expect_cmd(2'h0, 1'b0, 1'b0);
		wrap_up();
	end
endmodule
